// file: core/stepper_pkg.sv
// Function
// - advance only on step clock rising edge
// - mode low full-step, high half-step
// - direction low forward, high reverse
// - reset low holds sequencer, outputs off
// - enable low forces all outputs off
// - disabled sequencer keeps tracking step edges
// - after reset coil one fwd, two rev
// - mode change keeps current phase position
package stepper_pkg;
  // phase output bit positions in the coil word
  localparam int unsigned COIL_ONE_FWD = 0;
  localparam int unsigned COIL_TWO_FWD = 1;
  localparam int unsigned COIL_ONE_REV = 2;
  localparam int unsigned COIL_TWO_REV = 3;
  localparam int unsigned POS_W        = 3;
  localparam logic [2:0]  POS_RESET    = 3'h0;
  localparam logic [2:0]  POS_STEP_ONE = 3'h1;
  localparam logic [2:0]  POS_STEP_TWO = 3'h2;
  localparam logic [3:0]  COILS_OFF    = 4'h0;
  localparam int unsigned SYNC_STAGES  = 2;
  // controller-side timing, kept for reference by the checking side
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned RESET_HOLD_NS    = 10000;
  localparam int unsigned DIR_SETUP_PS     = 6250000;
  localparam int unsigned MODE_SETUP_NS    = 5000;
  localparam int unsigned STEP_PULSE_NS    = 10000;
  localparam int unsigned STEP_PULSE_CYC   = (STEP_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned RESET_HOLD_CYC   = (RESET_HOLD_NS * 1000) / CLK_PERIOD_PS;
endpackage : stepper_pkg

// file: core/pin_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// synchronised control levels passed from the pin stage to the sequencer
interface pin_sync_if;
  logic step_clock;
  logic half_step_mode;
  logic direction_select;
  logic reset_low_input;
  logic output_enable;
  modport sync (output step_clock, half_step_mode, direction_select,
                reset_low_input, output_enable);
  modport core (input step_clock, half_step_mode, direction_select,
                reset_low_input, output_enable);
endinterface : pin_sync_if
`default_nettype wire

// file: core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for the five asynchronous control pins
module pin_sync #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pins_in,
  pin_sync_if.sync              sync_out
);
  import stepper_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  // the interface carries exactly five levels
  if (WIDTH != 5) begin : g_width_check
    $error("pin_sync serves exactly five pins");
  end

  // first stage is read only by the second
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = pins_in;
    state_next.stable = state_reg.meta;
  end

  // reset idles all five pins low, which leaves the active-low reset asserted
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out.step_clock       = state_reg.stable[0];
  assign sync_out.half_step_mode   = state_reg.stable[1];
  assign sync_out.direction_select = state_reg.stable[2];
  assign sync_out.reset_low_input  = state_reg.stable[3];
  assign sync_out.output_enable    = state_reg.stable[4];
endmodule : pin_sync
`default_nettype wire

// file: core/stepper_phase_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// phase sequencer: eight-position electrical cycle, full-step uses the
// even (two-coil) positions, half-step walks all eight
module stepper_phase_sequencer (
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire logic                          step_clock,
  input  wire logic                          half_step_mode,
  input  wire logic                          direction_select,
  input  wire logic                          reset_low_input_n,
  input  wire logic                          output_enable,
  output var  logic [stepper_pkg::POS_W-1:0] phase_position,
  output var  logic                          coil_one_fwd,
  output var  logic                          coil_two_fwd,
  output var  logic                          coil_one_rev,
  output var  logic                          coil_two_rev
);
  import stepper_pkg::*;

  // the position tables below are written for an eight-step cycle
  if (POS_W != 3) begin : g_pos_width_check
    $error("sequencer tables need a three-bit position");
  end

  // the pin stage is built for exactly two flip-flops
  if (SYNC_STAGES != 2) begin : g_sync_depth_check
    $error("pin stage is built for two flip-flops");
  end

  // every phase output needs a bit inside the four-bit coil word
  if (COIL_ONE_FWD > 3 || COIL_TWO_FWD > 3 ||
      COIL_ONE_REV > 3 || COIL_TWO_REV > 3) begin : g_coil_bit_check
    $error("coil bit positions must fall inside the coil word");
  end

  // two phase outputs sharing a bit would be driven from one coil
  if (COIL_ONE_FWD == COIL_TWO_FWD || COIL_ONE_FWD == COIL_ONE_REV ||
      COIL_ONE_FWD == COIL_TWO_REV || COIL_TWO_FWD == COIL_ONE_REV ||
      COIL_TWO_FWD == COIL_TWO_REV || COIL_ONE_REV == COIL_TWO_REV) begin : g_coil_uniq_check
    $error("phase outputs need distinct coil bits");
  end

  // pin order on the synchroniser; the interface unpacks the same order
  logic [4:0] pin_word;
  assign pin_word[0] = step_clock;
  assign pin_word[1] = half_step_mode;
  assign pin_word[2] = direction_select;
  assign pin_word[3] = reset_low_input_n;
  assign pin_word[4] = output_enable;

  // synchronised levels, read by the sequencer only
  pin_sync_if pins ();

  // every pin passes two flip-flops before the sequencer reads it; this
  // costs two clocks of latency, far below the shortest step pulse
  pin_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .pins_in  (pin_word),
    .sync_out (pins)
  );

  typedef struct packed {
    logic             step_last;
    logic [POS_W-1:0] pos;
    logic [3:0]       coils;
  } seq_s;

  seq_s state_reg;
  seq_s state_next;

  // coil pattern for each of the eight positions
  // position 0: one-fwd + two-rev, then clockwise around the cycle
  function automatic logic [3:0] coil_map(input logic [POS_W-1:0] p);
    logic [3:0] c;
    c = COILS_OFF;
    case (p)
      3'h0: c = 4'h9;   // one_fwd + two_rev
      3'h1: c = 4'h1;   // one_fwd
      3'h2: c = 4'h3;   // one_fwd + two_fwd
      3'h3: c = 4'h2;   // two_fwd
      3'h4: c = 4'h6;   // two_fwd + one_rev
      3'h5: c = 4'h4;   // one_rev
      3'h6: c = 4'hC;   // one_rev + two_rev
      3'h7: c = 4'h8;   // two_rev
      default: c = COILS_OFF;
    endcase
    return c;
  endfunction

  // next position for one step, a table per mode and direction, so every
  // move, the wrap between seven and zero included, reads off directly;
  // mode and direction are looked at only here, at the step edge
  function automatic logic [POS_W-1:0] advance(input logic [POS_W-1:0] p,
                                               input logic half,
                                               input logic rev);
    logic [POS_W-1:0] n;
    n = p;
    case ({half, rev})
      // full-step forward: a pair moves two on; a lone coil, left over from
      // a half-step run, joins the next pair so the phase is kept
      2'b00: begin
        case (p)
          3'h0: n = 3'h2;
          3'h1: n = 3'h2;
          3'h2: n = 3'h4;
          3'h3: n = 3'h4;
          3'h4: n = 3'h6;
          3'h5: n = 3'h6;
          3'h6: n = 3'h0;
          3'h7: n = 3'h0;
          default: n = p;
        endcase
      end

      // full-step reverse: the same pairs in the opposite order; a lone
      // coil falls back onto the pair just behind it
      2'b01: begin
        case (p)
          3'h0: n = 3'h6;
          3'h1: n = 3'h0;
          3'h2: n = 3'h0;
          3'h3: n = 3'h2;
          3'h4: n = 3'h2;
          3'h5: n = 3'h4;
          3'h6: n = 3'h4;
          3'h7: n = 3'h6;
          default: n = p;
        endcase
      end

      // half-step forward: one position on, single and paired coils
      // taking turns
      2'b10: begin
        case (p)
          3'h0: n = 3'h1;
          3'h1: n = 3'h2;
          3'h2: n = 3'h3;
          3'h3: n = 3'h4;
          3'h4: n = 3'h5;
          3'h5: n = 3'h6;
          3'h6: n = 3'h7;
          3'h7: n = 3'h0;
          default: n = p;
        endcase
      end

      // half-step reverse: one position back
      2'b11: begin
        case (p)
          3'h0: n = 3'h7;
          3'h1: n = 3'h0;
          3'h2: n = 3'h1;
          3'h3: n = 3'h2;
          3'h4: n = 3'h3;
          3'h5: n = 3'h4;
          3'h6: n = 3'h5;
          3'h7: n = 3'h6;
          default: n = p;
        endcase
      end
      default: n = p;
    endcase
    return n;
  endfunction

  // the step edge and the position one step on, as named pieces
  logic             step_rise;
  logic [POS_W-1:0] pos_stepped;
  assign step_rise   = pins.step_clock && !state_reg.step_last;
  assign pos_stepped = advance(state_reg.pos, pins.half_step_mode,
                               pins.direction_select);

  // one update per clock; falling edges leave the position alone
  always_comb begin
    state_next = state_reg;
    if (!pins.reset_low_input) begin
      // held in reset, outputs off, position to start
      // the edge memory is held high, so a step clock already high when
      // the reset lets go is never taken as a rise
      state_next.step_last = 1'b1;
      state_next.pos       = POS_RESET;
      state_next.coils     = COILS_OFF;
    end else begin
      state_next.step_last = pins.step_clock;
      // act only on rising edges, even while disabled
      if (step_rise) begin
        state_next.pos = pos_stepped;
      end
      // enable gates outputs only, never the position
      if (pins.output_enable) begin
        state_next.coils = coil_map(state_next.pos);
      end else begin
        state_next.coils = COILS_OFF;
      end
    end
  end

  // no edge counted on the first cycle after reset: step_last starts high
  // so a step clock already high at release is not taken as a rise
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg.step_last <= 1'b1;
      state_reg.pos       <= POS_RESET;
      state_reg.coils     <= COILS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign phase_position = state_reg.pos;
  assign coil_one_fwd   = state_reg.coils[COIL_ONE_FWD];
  assign coil_two_fwd   = state_reg.coils[COIL_TWO_FWD];
  assign coil_one_rev   = state_reg.coils[COIL_ONE_REV];
  assign coil_two_rev   = state_reg.coils[COIL_TWO_REV];
endmodule : stepper_phase_sequencer
`default_nettype wire

// file: sim/stepper_properties.sv
`timescale 1ns/1ps
`default_nettype none
// pin effects reach the outputs three edges late, through the synchroniser
module stepper_properties (
  input wire logic                           clk_sys,
  input wire logic                           sys_rst,
  input wire logic                           step_clock,
  input wire logic                           half_step_mode,
  input wire logic                           direction_select,
  input wire logic                           reset_low_input_n,
  input wire logic                           output_enable,
  input wire logic [stepper_pkg::POS_W-1:0]  phase_position,
  input wire logic                           coil_one_fwd,
  input wire logic                           coil_two_fwd,
  input wire logic                           coil_one_rev,
  input wire logic                           coil_two_rev
);
  import stepper_pkg::*;
  localparam logic [3:0] MAP [8] = '{4'h9, 4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8};
  logic [3:0] coils;
  logic [2:0] pos;
  // coil word in package bit order
  assign coils = {coil_two_rev, coil_one_rev, coil_two_fwd, coil_one_fwd};
  assign pos   = phase_position;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a step rise three edges back, out of reset, with its mode and direction
  sequence s_go(h, r);
    $past(step_clock, 3) && !$past(step_clock, 4) && $past(reset_low_input_n, 3)
      && $past(half_step_mode, 3) == h && $past(direction_select, 3) == r;
  endsequence
  a_half_fwd: assert property (
    s_go(1'h1, 1'h0) |-> pos == $past(pos) + 3'h1) else $error("half fwd");
  a_half_rev: assert property (
    s_go(1'h1, 1'h1) |-> pos == $past(pos) - 3'h1) else $error("half rev");
  a_full_fwd: assert property (
    s_go(1'h0, 1'h0) |-> pos == $past(pos) + ($past(pos[0]) ? 3'h1 : 3'h2))
    else $error("full fwd");
  a_full_rev: assert property (
    s_go(1'h0, 1'h1) |-> pos == $past(pos) - ($past(pos[0]) ? 3'h1 : 3'h2))
    else $error("full rev");
  a_coil_map: assert property (
    coils != 4'h0 |-> coils == MAP[pos]) else $error("coil pattern");
  a_enable_off: assert property (
    !$past(output_enable, 3) |-> coils == 4'h0) else $error("enable");
  a_reset_hold: assert property (
    !$past(reset_low_input_n, 3) |-> pos == 3'h0 && coils == 4'h0) else $error("reset");
  a_step_cause: assert property (
    $changed(pos) |-> ($past(step_clock, 3) && !$past(step_clock, 4))
      || !$past(reset_low_input_n, 3)) else $error("stray move");
  // enabled and out of reset long enough for the pins to settle: coils live
  a_enable_map: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3) && !$past(sys_rst, 4)
      && $past(output_enable, 3) && $past(reset_low_input_n, 3) |-> coils == MAP[pos])
    else $error("coils off while enabled");
endmodule // stepper_properties
bind stepper_phase_sequencer stepper_properties stepper_properties_inst (.clk_sys, .sys_rst,
  .step_clock, .half_step_mode, .direction_select, .reset_low_input_n, .output_enable,
  .phase_position, .coil_one_fwd, .coil_two_fwd, .coil_one_rev, .coil_two_rev);
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host pins: levels change only mid-low, far from any step rise
module host_model #(
  parameter int unsigned HALF_CYC = 4
) (
  input  wire logic clk_sys,
  output var  logic step_clock,
  output var  logic half_step_mode,
  output var  logic direction_select,
  output var  logic reset_low_input_n,
  output var  logic output_enable
);
  // start held in reset with enable high
  initial {step_clock, half_step_mode, direction_select, reset_low_input_n, output_enable} = 5'h01;
  task automatic step(input logic half, input logic rev, input logic en);
    half_step_mode <= half;
    direction_select <= rev;
    output_enable <= en;
    repeat (HALF_CYC) @(posedge clk_sys);
    step_clock <= 1'h1;
    repeat (HALF_CYC) @(posedge clk_sys);
    step_clock <= 1'h0;
    repeat (HALF_CYC) @(posedge clk_sys);
  endtask
  task automatic hold_reset(input int unsigned cyc);
    reset_low_input_n <= 1'h0;
    repeat (cyc) @(posedge clk_sys);
    reset_low_input_n <= 1'h1;
    repeat (HALF_CYC) @(posedge clk_sys);
  endtask
endmodule // host_model
`default_nettype wire

// file: sim/stepper_phase_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stepper_phase_sequencer_tb;
  import stepper_pkg::*;
  localparam logic [3:0] MAP [8] = '{4'h9, 4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8};
  logic             clk_sys = 1'h0;
  logic             sys_rst = 1'h1;
  logic             step_clock, half_step_mode, direction_select, reset_low_input_n;
  logic             output_enable, coil_one_fwd, coil_two_fwd, coil_one_rev, coil_two_rev;
  logic [POS_W-1:0] phase_position;
  logic [3:0]       coils;
  logic [2:0]       exp_pos;
  int               error_cnt = 0;
  int               comparisons = 0;
  always #2.5 clk_sys = ~clk_sys;
  assign coils = {coil_two_rev, coil_one_rev, coil_two_fwd, coil_one_fwd};
  host_model host_model_inst (.clk_sys, .step_clock, .half_step_mode, .direction_select,
    .reset_low_input_n, .output_enable);
  stepper_phase_sequencer stepper_phase_sequencer_inst (.clk_sys, .sys_rst, .step_clock,
    .half_step_mode, .direction_select, .reset_low_input_n, .output_enable, .phase_position,
    .coil_one_fwd, .coil_two_fwd, .coil_one_rev, .coil_two_rev);
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // steps n times; full-step from an odd place moves one, else two
  task automatic run(input logic half, input logic rev, input logic en, input int n);
    repeat (n) begin
      host_model_inst.step(half, rev, en);
      exp_pos = exp_pos + ((half || exp_pos[0]) ? 3'h1 : 3'h2) * (rev ? 3'h7 : 3'h1);
      // look mid-cycle, clear of the edge that moves the outputs
      @(negedge clk_sys);
      check("pos", {1'h0, phase_position}, {1'h0, exp_pos});
      check("coils", coils, en ? MAP[exp_pos] : 4'h0);
      @(posedge clk_sys);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence: every mode and direction, mode switch at odd place, disable, reset
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    check("held", coils, 4'h0);
    @(posedge clk_sys);
    host_model_inst.hold_reset(RESET_HOLD_CYC);
    exp_pos = 3'h0;
    @(negedge clk_sys);
    check("init", coils, 4'h9);
    @(posedge clk_sys);
    run(1'h0, 1'h0, 1'h1, 5);
    run(1'h0, 1'h1, 1'h1, 5);
    run(1'h1, 1'h0, 1'h1, 9);
    run(1'h0, 1'h0, 1'h1, 1);
    run(1'h1, 1'h1, 1'h0, 3);
    run(1'h0, 1'h1, 1'h1, 2);
    host_model_inst.hold_reset(RESET_HOLD_CYC);
    @(negedge clk_sys);
    check("rst pos", {1'h0, phase_position}, 4'h0);
    check("rst coils", coils, 4'h9);
    print_verdict();
  end
  // watchdog well beyond the expected run of about 4350 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end
endmodule // stepper_phase_sequencer_tb
`default_nettype wire
